// ---- shared/usc_pkg.sv ----
`default_nettype none

package usc_pkg;

	// ----------------------------------------------------------------
	// link widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_QTY = 5;

	// ----------------------------------------------------------------
	// device register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_HOUR_HIGH = 8'hfc;
	localparam logic [7:0] OFF_HOUR_LOW = 8'hfd;
	localparam logic [7:0] OFF_READY = 8'hfe;
	localparam logic [7:0] OFF_CONTROL = 8'hff;
	localparam logic [7:0] OFF_PASSWORD = 8'h7b;
	// result high bytes: temperature, voltage, bias, transmit, receive
	localparam logic [7:0] OFF_RESULT [NUM_QTY] = '{8'h60, 8'h62, 8'h64, 8'h66, 8'h68};
	localparam logic [7:0] RESULT_LOW_STEP = 8'h01;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int HOUR_FAULT_BIT = 7;
	localparam int HOUR_HIGH_W = 7;
	localparam int HOUR_W = 15;
	localparam int READY_LSB = 3;
	localparam int CTRL_MASK_BIT = 6;
	localparam int CTRL_FLAG_BIT = 5;
	localparam int CTRL_IE_BIT = 4;
	localparam int CTRL_SEL_LSB = 2;
	localparam logic [7:0] CTRL_NV_BITS = 8'h5c;
	localparam logic [7:0] CTRL_RESERVED = 8'h83;
	localparam logic [7:0] CTRL_RESET = 8'h20;
	localparam logic [7:0] READY_RESET = 8'h00;
	localparam logic [7:0] HOUR_RESET = 8'h00;

	// ----------------------------------------------------------------
	// non-volatile word map
	// ----------------------------------------------------------------
	localparam int NV_HOUR_HIGH = 0;
	localparam int NV_HOUR_LOW = 1;
	localparam int NV_CONTROL = 2;
	localparam int NV_WORDS = 3;

	// ----------------------------------------------------------------
	// controller registers on the avalon side
	// ----------------------------------------------------------------
	localparam logic [3:0] AV_CMD = 4'h0;
	localparam logic [3:0] AV_STATUS = 4'h4;
	localparam logic [3:0] AV_HOUR = 4'h8;
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_OP_LSB = 16;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_IRQ_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_UNLOCKED_BIT = 3;
	localparam int ST_RDATA_LSB = 8;
	localparam int HOUR_VALID_BIT = 15;

	typedef enum logic [1:0] {
		USC_OP_READ,
		USC_OP_WRITE,
		USC_OP_HOUR,
		USC_OP_NONE
	} usc_op_e;

endpackage

`default_nettype wire

// ---- shared/usc_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface usc_link_if (
	input wire logic core_clk_i,
	input wire logic rst_n_i
);
	logic req;
	logic wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	logic irq_n;

	modport device (
		input req,
		input wr,
		input addr,
		input wdata,
		output ack,
		output rdata,
		output irq_n
	);

	modport host (
		output req,
		output wr,
		output addr,
		output wdata,
		input ack,
		input rdata,
		input irq_n
	);
endinterface

`default_nettype wire

// ---- src/usc_nv_store.sv ----
`timescale 1ns/1ps
`default_nettype none

module usc_nv_store #(
	parameter int DEPTH = 3,
	parameter int WIDTH = 8,
	parameter logic [7:0] INIT_VALUE = 8'h00
) (
	input wire logic core_clk_i,
	input wire logic [DEPTH-1:0] we_i,
	input wire logic [WIDTH-1:0] wd_i [DEPTH],
	output logic [WIDTH-1:0] q_o [DEPTH]
);
	// ----------------------------------------------------------------
	// storage kept outside the reset tree
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH < 1 || WIDTH < 1 || WIDTH > 8) begin : g_check
		$error("usc_nv_store: unsupported DEPTH or WIDTH");
	end

	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = INIT_VALUE[WIDTH-1:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (we_i[i]) begin
				mem[i] <= wd_i[i];
			end
		end
	end

	assign q_o = mem;
endmodule

`default_nettype wire

// ---- src/usc_device.sv ----
// Function
// - hour meter is fifteen bits, split
// - high byte bit seven flags corruption
// - host ignores hours while corrupt
// - host reads high then low together
// - hour bytes survive power and reset
// - conversion done sets its ready flag
// - reading a result clears its flag
// - ready flags at bits seven to three
// - flag one means fresh result waiting
// - selector picks first, second, third setpoint
// - no interrupt without global enable
// - power-on and warm reset both interrupt
// - masked power-on event sets power-on flag
// - control read clears flag, releases output
// - writing enable releases asserted output
// - host still reads each pending flag
// - late mask leaves flag and output
// - mask, enable, selector survive reset
// - control access needs user password
// - reserved control bits written as zero
`timescale 1ns/1ps
`default_nettype none

module usc_device #(
	parameter logic [7:0] PASSWORD = 8'h5a
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	usc_link_if.device link,
	input wire logic [usc_pkg::NUM_QTY-1:0] conv_done_i,
	input wire logic [15:0] result_i [usc_pkg::NUM_QTY],
	input wire logic hour_update_i,
	input wire logic [usc_pkg::HOUR_W-1:0] hour_value_i,
	input wire logic hour_fault_i,
	output logic [1:0] setpoint_selector_o
);
	import usc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] nv_q [NV_WORDS];
	logic [7:0] nv_wd [NV_WORDS];
	logic [NV_WORDS-1:0] nv_we;
	logic take, is_rd, is_wr, unlocked, ctrl_rd, ctrl_wr;
	logic por_pending, flag, irq_active, snap_valid, ack, irq_n;
	logic [7:0] snap_low, next_rdata, rdata;
	logic [NUM_QTY-1:0] ready, result_hit;

	if (NUM_QTY + READY_LSB > 8) begin : g_check
		$error("usc_device: ready flags do not fit the byte");
	end

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic result_addr(input logic [7:0] a, input logic [7:0] off);
		result_addr = hit(a, off) | hit(a, off + RESULT_LOW_STEP);
	endfunction

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	assign take = link.req & ~ack;
	assign is_rd = take & ~link.wr;
	assign is_wr = take & link.wr;
	assign ctrl_rd = is_rd & hit(link.addr, OFF_CONTROL) & unlocked;
	assign ctrl_wr = is_wr & hit(link.addr, OFF_CONTROL) & unlocked;

	always_comb begin
		for (int i = 0; i < NUM_QTY; i++) begin
			result_hit[i] = is_rd & result_addr(link.addr, OFF_RESULT[i]);
		end
	end

	// ----------------------------------------------------------------
	// password gate
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unlocked <= 1'b0;
		end else if (is_wr && hit(link.addr, OFF_PASSWORD)) begin
			unlocked <= (link.wdata == PASSWORD);
		end
	end

	// ----------------------------------------------------------------
	// non-volatile bytes
	// ----------------------------------------------------------------
	always_comb begin
		nv_we = '0;
		nv_wd[NV_HOUR_HIGH] = nv_q[NV_HOUR_HIGH];
		nv_wd[NV_HOUR_LOW] = nv_q[NV_HOUR_LOW];
		nv_wd[NV_CONTROL] = nv_q[NV_CONTROL];
		if (hour_update_i) begin
			nv_we[NV_HOUR_HIGH] = 1'b1;
			nv_we[NV_HOUR_LOW] = 1'b1;
			nv_wd[NV_HOUR_HIGH] = {hour_fault_i, hour_value_i[HOUR_W-1:8]};
			nv_wd[NV_HOUR_LOW] = hour_value_i[7:0];
		end else if (is_wr && hit(link.addr, OFF_HOUR_HIGH)) begin
			nv_we[NV_HOUR_HIGH] = 1'b1;
			nv_wd[NV_HOUR_HIGH] = {nv_q[NV_HOUR_HIGH][HOUR_FAULT_BIT],
				link.wdata[HOUR_HIGH_W-1:0]};
		end else if (is_wr && hit(link.addr, OFF_HOUR_LOW)) begin
			nv_we[NV_HOUR_LOW] = 1'b1;
			nv_wd[NV_HOUR_LOW] = link.wdata;
		end
		if (ctrl_wr) begin
			nv_we[NV_CONTROL] = 1'b1;
			nv_wd[NV_CONTROL] = link.wdata & CTRL_NV_BITS;
		end
	end

	usc_nv_store #(
		.DEPTH(NV_WORDS),
		.WIDTH(8),
		.INIT_VALUE(HOUR_RESET)
	) u_nv (
		.core_clk_i(core_clk_i),
		.we_i(nv_we),
		.wd_i(nv_wd),
		.q_o(nv_q)
	);

	// code 11 is passed through; the setpoint side treats it as the first
	assign setpoint_selector_o = nv_q[NV_CONTROL][CTRL_SEL_LSB +: 2];

	// ----------------------------------------------------------------
	// data-ready flags
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ready <= READY_RESET[READY_LSB +: NUM_QTY];
		end else begin
			for (int i = 0; i < NUM_QTY; i++) begin
				if (conv_done_i[i]) begin
					ready[i] <= 1'b1;
				end else if (result_hit[i]) begin
					ready[i] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// power-on flag and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			por_pending <= 1'b1;
		end else begin
			por_pending <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag <= 1'b0;
		end else if (por_pending && nv_q[NV_CONTROL][CTRL_MASK_BIT]) begin
			flag <= 1'b1;
		end else if (ctrl_rd) begin
			flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_active <= 1'b0;
		end else if (por_pending && nv_q[NV_CONTROL][CTRL_MASK_BIT]
				&& nv_q[NV_CONTROL][CTRL_IE_BIT]) begin
			irq_active <= 1'b1;
		end else if (ctrl_rd) begin
			irq_active <= 1'b0;
		end else if (ctrl_wr) begin
			irq_active <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= ~irq_active;
		end
	end

	// ----------------------------------------------------------------
	// coherent hour pair
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			snap_valid <= 1'b0;
			snap_low <= HOUR_RESET;
		end else if (is_rd && hit(link.addr, OFF_HOUR_HIGH)) begin
			snap_valid <= 1'b1;
			snap_low <= nv_q[NV_HOUR_LOW];
		end else if (take) begin
			snap_valid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		unique case (link.addr)
			OFF_HOUR_HIGH: begin
				next_rdata = nv_q[NV_HOUR_HIGH];
			end
			OFF_HOUR_LOW: begin
				next_rdata = snap_valid ? snap_low : nv_q[NV_HOUR_LOW];
			end
			OFF_READY: begin
				for (int i = 0; i < NUM_QTY; i++) begin
					next_rdata[READY_LSB + NUM_QTY - 1 - i] = ready[i];
				end
			end
			OFF_CONTROL: begin
				if (unlocked) begin
					next_rdata = nv_q[NV_CONTROL] & CTRL_NV_BITS;
					next_rdata[CTRL_FLAG_BIT] = flag;
				end
			end
			default: begin
				for (int i = 0; i < NUM_QTY; i++) begin
					if (hit(link.addr, OFF_RESULT[i])) begin
						next_rdata = result_i[i][15:8];
					end else if (hit(link.addr, OFF_RESULT[i] + RESULT_LOW_STEP)) begin
						next_rdata = result_i[i][7:0];
					end
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// answer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack <= 1'b0;
		end else begin
			ack <= take;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata <= 8'h00;
		end else if (is_rd) begin
			rdata <= next_rdata;
		end
	end

	assign link.ack = ack;
	assign link.rdata = rdata;
	assign link.irq_n = irq_n;
endmodule

`default_nettype wire

// ---- src/usc_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module usc_host (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	usc_link_if.host link
);
	import usc_pkg::*;

	typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_GAP} usc_host_state_e;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	usc_host_state_e state;
	logic req;
	logic wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic pair;
	logic unlocked;
	logic refused;
	logic [7:0] last_rdata;
	logic [7:0] hour_high;
	logic [15:0] hour;
	logic accept;
	logic cmd_wr;
	logic st_rd;
	usc_op_e op;
	logic [7:0] cmd_addr;
	logic [7:0] cmd_data;
	logic cmd_refused;

	assign accept = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
	assign cmd_wr = accept & avs_write_i & (avs_address_i == AV_CMD);
	assign st_rd = accept & avs_read_i & (avs_address_i == AV_STATUS);
	assign op = usc_op_e'(avs_writedata_i[CMD_OP_LSB +: 2]);
	assign cmd_addr = avs_writedata_i[CMD_ADDR_LSB +: 8];
	assign cmd_data = avs_writedata_i[CMD_DATA_LSB +: 8];
	assign cmd_refused = (state != HS_IDLE) | (op == USC_OP_NONE)
		| ((cmd_addr == OFF_CONTROL) & ~unlocked & (op != USC_OP_HOUR));

	// ----------------------------------------------------------------
	// avalon slave
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= '0;
		end else if (avs_read_i && avs_waitrequest_o) begin
			avs_readdata_o <= '0;
			if (avs_address_i == AV_STATUS) begin
				avs_readdata_o[ST_BUSY_BIT] <= (state != HS_IDLE);
				avs_readdata_o[ST_IRQ_BIT] <= ~link.irq_n;
				avs_readdata_o[ST_REFUSED_BIT] <= refused;
				avs_readdata_o[ST_UNLOCKED_BIT] <= unlocked;
				avs_readdata_o[ST_RDATA_LSB +: 8] <= last_rdata;
			end else if (avs_address_i == AV_HOUR) begin
				avs_readdata_o[15:0] <= hour;
			end
		end
	end

	// ----------------------------------------------------------------
	// link sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= HS_IDLE;
			req <= 1'b0;
			wr <= 1'b0;
			addr <= 8'h00;
			wdata <= 8'h00;
			pair <= 1'b0;
		end else begin
			unique case (state)
				HS_IDLE: begin
					if (cmd_wr && !cmd_refused) begin
						state <= HS_WAIT;
						req <= 1'b1;
						wr <= (op == USC_OP_WRITE);
						pair <= (op == USC_OP_HOUR);
						addr <= (op == USC_OP_HOUR) ? OFF_HOUR_HIGH : cmd_addr;
						wdata <= (cmd_addr == OFF_CONTROL) ? (cmd_data & ~CTRL_RESERVED)
							: cmd_data;
					end
				end
				HS_WAIT: begin
					if (link.ack) begin
						req <= 1'b0;
						state <= pair ? HS_GAP : HS_IDLE;
					end
				end
				HS_GAP: begin
					pair <= 1'b0;
					req <= 1'b1;
					addr <= OFF_HOUR_LOW;
					state <= HS_WAIT;
				end
				default: begin
					state <= HS_IDLE;
					req <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// results and status
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_rdata <= 8'h00;
			hour_high <= 8'h00;
			hour <= 16'h0000;
		end else if (state == HS_WAIT && link.ack && !wr) begin
			last_rdata <= link.rdata;
			if (pair) begin
				hour_high <= link.rdata;
			end else if (addr == OFF_HOUR_LOW) begin
				hour[HOUR_VALID_BIT] <= ~hour_high[HOUR_FAULT_BIT];
				hour[HOUR_W-1:0] <= hour_high[HOUR_FAULT_BIT] ? '0
					: {hour_high[HOUR_HIGH_W-1:0], link.rdata};
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unlocked <= 1'b0;
		end else if (cmd_wr && !cmd_refused && op == USC_OP_WRITE
				&& cmd_addr == OFF_PASSWORD) begin
			unlocked <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			refused <= 1'b0;
		end else if (cmd_wr && cmd_refused) begin
			refused <= 1'b1;
		end else if (st_rd) begin
			refused <= 1'b0;
		end
	end

	assign link.req = req;
	assign link.wr = wr;
	assign link.addr = addr;
	assign link.wdata = wdata;
endmodule

`default_nettype wire

// ---- dv/usc_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// link checker
// ----------------------------------------------------------------
module usc_link_sva (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic req,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic [7:0] rdata,
	input wire logic irq_n
);
	logic ctl_acc;
	logic [2:0] since_rst;

	assign ctl_acc = req && (addr == 8'hff);

	// cycles since reset release, saturating
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			since_rst <= 3'h0;
		end else if (since_rst != 3'h7) begin
			since_rst <= since_rst + 3'h1;
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_ack_pulse; ack |=> !ack; endproperty
	property p_ack_answer; req && !ack |=> ack; endproperty
	property p_ack_cause; ack |-> $past(req); endproperty
	property p_req_hold;
		req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata);
	endproperty
	property p_req_drop; ack |=> !req; endproperty
	property p_ctl_read; req && !ack && !wr && addr == 8'hff |-> ##[1:3] irq_n; endproperty
	property p_ctl_write; req && !ack && wr && addr == 8'hff |-> ##[1:3] irq_n; endproperty
	property p_irq_hold; !irq_n && !ctl_acc && !$past(ctl_acc) |=> !irq_n; endproperty
	property p_irq_power_on; $fell(irq_n) |-> since_rst <= 3'h4; endproperty
	property p_rdata_hold; $changed(rdata) |-> ack && !wr; endproperty

	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
	a_req_drop: assert property (p_req_drop) else $error("request held after ack");
	a_ctl_read: assert property (p_ctl_read) else $error("control read kept irq");
	a_ctl_write: assert property (p_ctl_write) else $error("control write kept irq");
	a_irq_hold: assert property (p_irq_hold) else $error("irq released early");
	a_irq_power_on: assert property (p_irq_power_on) else $error("irq not at power-on");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");

	c_read: cover property (ack && !wr);
	c_write: cover property (ack && wr);
	c_irq: cover property ($fell(irq_n));
endmodule

`default_nettype wire

// ---- dv/user_status_control_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end

// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module user_status_control_regs_test;
	import usc_pkg::*;
	localparam logic [7:0] PWD = 8'h5a;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [NUM_QTY-1:0] conv_done_i = '0;
	logic [15:0] result_i [NUM_QTY];
	logic hour_update_i = 1'b0;
	logic [HOUR_W-1:0] hour_value_i = '0;
	logic hour_fault_i = 1'b0;
	logic [1:0] setpoint_selector_o;
	int n_errors = 0;
	int checked = 0;
	logic [31:0] q;
	logic [7:0] b;

	always #2.5 core_clk_i = ~core_clk_i;

	usc_link_if i_usc_link_if (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i));
	usc_device #(.PASSWORD(PWD)) i_usc_device (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.link(i_usc_link_if), .conv_done_i(conv_done_i), .result_i(result_i),
		.hour_update_i(hour_update_i), .hour_value_i(hour_value_i),
		.hour_fault_i(hour_fault_i), .setpoint_selector_o(setpoint_selector_o));
	usc_host i_usc_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .link(i_usc_link_if));
	usc_link_sva i_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.req(i_usc_link_if.req), .wr(i_usc_link_if.wr), .addr(i_usc_link_if.addr),
		.wdata(i_usc_link_if.wdata), .ack(i_usc_link_if.ack),
		.rdata(i_usc_link_if.rdata), .irq_n(i_usc_link_if.irq_n));

	task automatic close_out();
		$display("counts: checked %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
	endtask

	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (avs_waitrequest_o !== 1'b0) begin
			n_errors++;
			close_out();
		end
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic cmd(input usc_op_e op, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		av(1'b1, AV_CMD, {14'h0, op, d, a});
		do begin
			av(1'b0, AV_STATUS, 32'h0);
			n++;
		end while (q[ST_BUSY_BIT] !== 1'b0 && n < 50);
		if (n >= 50) begin
			n_errors++;
			close_out();
		end
		b = q[ST_RDATA_LSB +: 8];
	endtask

	task automatic rd(input logic [7:0] a);
		cmd(USC_OP_READ, a, 8'h00);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cmd(USC_OP_WRITE, a, d);
	endtask

	task automatic hour_load(input logic f);
		@(posedge core_clk_i);
		hour_update_i <= 1'b1;
		hour_value_i <= 15'h5a3c;
		hour_fault_i <= f;
		@(posedge core_clk_i);
		hour_update_i <= 1'b0;
	endtask

	task automatic conv(input logic [NUM_QTY-1:0] m);
		@(posedge core_clk_i);
		conv_done_i <= m;
		@(posedge core_clk_i);
		conv_done_i <= '0;
	endtask

	task automatic t_hour();
		rd(OFF_HOUR_LOW);
		`CHK(b, HOUR_RESET)
		hour_load(1'b0);
		cmd(USC_OP_HOUR, OFF_HOUR_HIGH, 8'h00);
		av(1'b0, AV_HOUR, 32'h0);
		`CHK(q[15:0], 16'hda3c)
		rd(OFF_HOUR_HIGH);
		`CHK(b, 8'h5a)
		rd(OFF_HOUR_LOW);
		`CHK(b, 8'h3c)
		do_reset();
		rd(OFF_HOUR_HIGH);
		`CHK(b, 8'h5a)
		hour_load(1'b1);
		rd(OFF_HOUR_HIGH);
		`CHK(b, 8'hda)
		cmd(USC_OP_HOUR, OFF_HOUR_HIGH, 8'h00);
		av(1'b0, AV_HOUR, 32'h0);
		`CHK(q[15:0], 16'h0000)
		wr(OFF_HOUR_HIGH, 8'h05);
		wr(OFF_HOUR_LOW, 8'h22);
		rd(OFF_HOUR_HIGH);
		`CHK(b, 8'h85)
		rd(OFF_HOUR_LOW);
		`CHK(b, 8'h22)
		$display("test hour done");
	endtask

	task automatic t_ready();
		conv(5'h1f);
		rd(OFF_READY);
		`CHK(b, 8'hf8)
		for (int i = 0; i < NUM_QTY; i++) begin
			rd(OFF_RESULT[i]);
			`CHK(b, result_i[i][15:8])
			rd(OFF_READY);
			`CHK(b, 8'((8'hf8 >> (i + 1)) & 8'hf8))
		end
		conv(5'h04);
		rd(OFF_READY);
		`CHK(b, 8'h20)
		rd(OFF_RESULT[2] + RESULT_LOW_STEP);
		`CHK(b, result_i[2][7:0])
		rd(OFF_READY);
		`CHK(b, READY_RESET)
		$display("test ready done");
	endtask

	task automatic t_ctrl();
		do_reset();
		wr(OFF_CONTROL, 8'h10);
		`CHK(q[ST_REFUSED_BIT], 1'b1)
		wr(OFF_PASSWORD, PWD);
		rd(OFF_CONTROL);
		`CHK(b, 8'h00)
		for (int c = 0; c < 4; c++) begin
			wr(OFF_CONTROL, 8'(c << 2) | CTRL_RESERVED);
			rd(OFF_CONTROL);
			`CHK(b, 8'(c << 2))
			`CHK(setpoint_selector_o, 2'(c))
		end
		wr(OFF_CONTROL, 8'h18);
		do_reset();
		`CHK(setpoint_selector_o, 2'b10)
		`CHK(i_usc_link_if.irq_n, 1'b1)
		$display("test control done");
	endtask

	task automatic t_irq();
		wr(OFF_PASSWORD, PWD);
		wr(OFF_CONTROL, 8'h40);
		do_reset();
		`CHK(i_usc_link_if.irq_n, 1'b1)
		wr(OFF_PASSWORD, PWD);
		rd(OFF_CONTROL);
		`CHK(b, 8'h60)
		wr(OFF_CONTROL, 8'h50);
		do_reset();
		`CHK(i_usc_link_if.irq_n, 1'b0)
		av(1'b0, AV_STATUS, 32'h0);
		`CHK(q[ST_IRQ_BIT], 1'b1)
		wr(OFF_PASSWORD, PWD);
		`CHK(i_usc_link_if.irq_n, 1'b0)
		rd(OFF_CONTROL);
		`CHK(b, 8'h70)
		`CHK(i_usc_link_if.irq_n, 1'b1)
		rd(OFF_CONTROL);
		`CHK(b, 8'h50)
		do_reset();
		wr(OFF_PASSWORD, PWD);
		wr(OFF_CONTROL, 8'h50);
		`CHK(i_usc_link_if.irq_n, 1'b1)
		rd(OFF_CONTROL);
		`CHK(b, 8'h70)
		wr(OFF_PASSWORD, 8'h00);
		rd(OFF_CONTROL);
		`CHK(b, 8'h00)
		$display("test interrupt done");
	endtask

	initial begin
		foreach (result_i[i]) begin
			result_i[i] = {8'h10 + 8'(i), 8'h20 + 8'(i)};
		end
		do_reset();
		t_hour();
		t_ready();
		t_ctrl();
		t_irq();
		close_out();
	end
endmodule

`default_nettype wire
